// ### hw/timing_nco_control.sv
// module: timing oscillator control registers, transfers and APB slave
//
// How it works
// [RQ1] sync ignored while sync enable is clear
// [RQ2] enabled sync copies held frequency and phase
// [RQ3] width code selects 8/16/24/32 offset bits
// [RQ4] offset disabled feeds zero to adder
// [RQ5] clear bit zeroes accumulator feedback
// [RQ6] load-on-update zeroes feedback on frequency strobe and sync transfers
// [RQ7] 32-bit word sets rate up to input rate
// [RQ8] frequency word is holding register only
// [RQ9] 8-bit phase offset spans one input period
// [RQ10] phase word is holding register only
// [RQ11] frequency strobe write transfers held frequency
// [RQ12] everything clocked by the processing clock
// [RQ13] phase strobe write transfers held phase
// [RQ14] accumulator advances by frequency plus offset
`timescale 1ns/1ps
module timing_nco_control (
    // processing clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // datapath
    input  wire logic        external_sync_in,
    input  wire logic        resampleTick,
    // oscillator state
    output logic [31:0]      activeFreq,
    output logic [7:0]       activePhase,
    output logic [31:0]      ncoPhase,
    output logic [31:0]      phaseAccum
);

    timing_nco_pkg::regs_type regs_r;
    timing_nco_pkg::regs_type regs_nxt;

    logic        wrEn;
    logic        rdEn;
    logic        mapped;
    logic [7:0]  idx;
    logic        syncLoad;
    logic        freqStrobe;
    logic        phaseStrobe;
    logic        zeroFeedback;
    logic [31:0] ofsEff;
    logic [31:0] step;

    // =====================================================
    // bus decode
    function automatic logic isMapped(input logic [7:0] i);
        case (i)
            timing_nco_pkg::IDX_CONFIG,
            timing_nco_pkg::IDX_FREQ_HOLD,
            timing_nco_pkg::IDX_PHASE_HOLD,
            timing_nco_pkg::IDX_FREQ_STROBE,
            timing_nco_pkg::IDX_PHASE_STROBE,
            timing_nco_pkg::IDX_OFFSET_FREQ,
            timing_nco_pkg::IDX_ACT_FREQ,
            timing_nco_pkg::IDX_ACT_PHASE,
            timing_nco_pkg::IDX_PHASE_ACC: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // keep the low offset bits selected by the width code
    function automatic logic [31:0] widthMask(input logic [1:0] code);
        case (code)
            timing_nco_pkg::OFS_W8:  widthMask = 32'h0000_00FF;
            timing_nco_pkg::OFS_W16: widthMask = 32'h0000_FFFF;
            timing_nco_pkg::OFS_W24: widthMask = 32'h00FF_FFFF;
            default:                 widthMask = 32'hFFFF_FFFF;
        endcase
    endfunction

    assign idx     = paddr[9:2];
    assign mapped  = isMapped(idx) && (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0);
    assign wrEn    = psel && penable && pwrite && mapped;
    assign rdEn    = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // =====================================================
    // transfer events, all on the processing clock (see [RQ12])
    assign syncLoad    = regs_r.cfg[timing_nco_pkg::CFG_SYNC_EN] && external_sync_in; // see [RQ1]
    assign freqStrobe  = wrEn && (idx == timing_nco_pkg::IDX_FREQ_STROBE); // see [RQ11]
    assign phaseStrobe = wrEn && (idx == timing_nco_pkg::IDX_PHASE_STROBE); // see [RQ13]

    assign zeroFeedback = regs_r.cfg[timing_nco_pkg::CFG_CLEAR_ACC] // see [RQ5]
        || (regs_r.cfg[timing_nco_pkg::CFG_LOAD_ON_UPD] && (freqStrobe || syncLoad)); // see [RQ6]

    // =====================================================
    // offset path into the adder
    always_comb begin
        ofsEff = regs_r.offsetFreq
            & widthMask(regs_r.cfg[timing_nco_pkg::CFG_OFS_W_LO +: 2]); // see [RQ3]
        if (!regs_r.cfg[timing_nco_pkg::CFG_OFS_EN]) begin
            ofsEff = timing_nco_pkg::RST_WORD; // see [RQ4]
        end
    end

    assign step = regs_r.actFreq + ofsEff; // see [RQ14]

    // =====================================================
    // register next state
    always_comb begin
        regs_nxt = regs_r;
        if (wrEn) begin
            case (idx)
                timing_nco_pkg::IDX_CONFIG:
                    regs_nxt.cfg = pwdata & timing_nco_pkg::CFG_MASK;
                timing_nco_pkg::IDX_FREQ_HOLD:
                    regs_nxt.freqHold = pwdata; // see [RQ7]
                timing_nco_pkg::IDX_PHASE_HOLD:
                    regs_nxt.phaseHold = pwdata[7:0];
                timing_nco_pkg::IDX_OFFSET_FREQ:
                    regs_nxt.offsetFreq = pwdata;
                default: begin
                end
            endcase
        end
        // holding values reach the active side only on strobe or sync
        if (freqStrobe || syncLoad) begin
            regs_nxt.actFreq = regs_r.freqHold; // see [RQ8] see [RQ2]
        end
        if (phaseStrobe || syncLoad) begin
            regs_nxt.actPhase = regs_r.phaseHold; // see [RQ10] see [RQ2]
        end
        // read data captured in setup, presented in access phase; refused reads return zero
        if (rdEn && !mapped) begin
            regs_nxt.rdata = timing_nco_pkg::RST_WORD;
        end else if (rdEn) begin
            case (idx)
                timing_nco_pkg::IDX_CONFIG:      regs_nxt.rdata = regs_r.cfg;
                timing_nco_pkg::IDX_FREQ_HOLD:   regs_nxt.rdata = regs_r.freqHold;
                timing_nco_pkg::IDX_PHASE_HOLD:  regs_nxt.rdata = {24'h000000, regs_r.phaseHold};
                timing_nco_pkg::IDX_OFFSET_FREQ: regs_nxt.rdata = regs_r.offsetFreq;
                timing_nco_pkg::IDX_ACT_FREQ:    regs_nxt.rdata = regs_r.actFreq;
                timing_nco_pkg::IDX_ACT_PHASE:   regs_nxt.rdata = {24'h000000, regs_r.actPhase};
                timing_nco_pkg::IDX_PHASE_ACC:   regs_nxt.rdata = phaseAccum;
                default:                         regs_nxt.rdata = timing_nco_pkg::RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            regs_r <= '0;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // =====================================================
    // accumulator
    timing_nco_accum accum (
        .clock        (clock),
        .rstn         (rstn),
        .sampleTick   (resampleTick),
        .zeroFeedback (zeroFeedback),
        .step         (step),
        .phaseOffset  (regs_r.actPhase),
        .phaseAcc     (phaseAccum),
        .phaseOut     (ncoPhase)
    );

    assign prdata      = regs_r.rdata;
    assign activeFreq  = regs_r.actFreq;
    assign activePhase = regs_r.actPhase;

endmodule

// ### hw/timing_nco_pkg.sv
// package: register map, config fields and carriers for the timing oscillator control
package timing_nco_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_CONFIG      = 8'h0B;
    localparam logic [7:0]  IDX_FREQ_HOLD   = 8'h0C;
    localparam logic [7:0]  IDX_PHASE_HOLD  = 8'h0D;
    localparam logic [7:0]  IDX_FREQ_STROBE = 8'h0E;
    localparam logic [7:0]  IDX_PHASE_STROBE = 8'h0F;
    // own registers: offset frequency input value, status readbacks
    localparam logic [7:0]  IDX_OFFSET_FREQ = 8'h20;
    localparam logic [7:0]  IDX_ACT_FREQ    = 8'h21;
    localparam logic [7:0]  IDX_ACT_PHASE   = 8'h22;
    localparam logic [7:0]  IDX_PHASE_ACC   = 8'h23;

    // config field positions
    localparam int CFG_LOAD_ON_UPD = 0;
    localparam int CFG_CLEAR_ACC   = 1;
    localparam int CFG_OFS_EN      = 2;
    localparam int CFG_OFS_W_LO    = 3;
    localparam int CFG_SYNC_EN     = 5;
    localparam logic [31:0] CFG_MASK    = 32'h0000_003F;
    localparam logic [31:0] PHASE_MASK  = 32'h0000_00FF;

    // reset values
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [7:0]  RST_BYTE    = 8'h00;

    // offset width codes
    localparam logic [1:0] OFS_W8  = 2'h0;
    localparam logic [1:0] OFS_W16 = 2'h1;
    localparam logic [1:0] OFS_W24 = 2'h2;
    localparam logic [1:0] OFS_W32 = 2'h3;

    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] freqHold;
        logic [7:0]  phaseHold;
        logic [31:0] offsetFreq;
        logic [31:0] actFreq;
        logic [7:0]  actPhase;
        logic [31:0] rdata;
    } regs_type;

    typedef struct packed {
        logic [31:0] phaseAcc;
        logic [31:0] phase;
    } nco_type;

endpackage

// ### hw/timing_nco_accum.sv
// module: phase accumulator of the timing oscillator
`timescale 1ns/1ps
module timing_nco_accum (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // controls
    input  wire logic        sampleTick,
    input  wire logic        zeroFeedback,
    input  wire logic [31:0] step,
    input  wire logic [7:0]  phaseOffset,
    // state out
    output logic [31:0]      phaseAcc,
    output logic [31:0]      phaseOut
);

    timing_nco_pkg::nco_type state_r;
    timing_nco_pkg::nco_type state_nxt;

    // =====================================================
    // next state
    always_comb begin
        logic [31:0] fb;
        fb = zeroFeedback ? timing_nco_pkg::RST_WORD : state_r.phaseAcc; // see [RQ5]
        state_nxt = state_r;
        if (sampleTick) begin
            state_nxt.phaseAcc = fb + step; // see [RQ14]
        end else if (zeroFeedback) begin
            state_nxt.phaseAcc = timing_nco_pkg::RST_WORD;
        end
        // offset spans one input period in its top byte
        state_nxt.phase = state_nxt.phaseAcc + {phaseOffset, 24'h000000}; // see [RQ9]
    end

    // =====================================================
    // registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign phaseAcc = state_r.phaseAcc;
    assign phaseOut = state_r.phase;

endmodule

// ### bench/timing_nco_control_chk.sv
// checker: transfer, hold and accumulator properties of the timing oscillator control
`timescale 1ns/1ps
module timing_nco_control_chk (
    // clock and bus
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // oscillator
    input wire logic        external_sync_in,
    input wire logic        resampleTick,
    input wire logic [31:0] activeFreq,
    input wire logic [7:0]  activePhase,
    input wire logic [31:0] phaseAccum
);
    logic [31:0] cfg_r;
    logic [31:0] fHold_r;
    logic [7:0]  pHold_r;
    wire         wr     = psel && penable && pwrite;
    wire         syncOn = external_sync_in && cfg_r[5];
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cfg_r   <= 32'h0;
            fHold_r <= 32'h0;
            pHold_r <= 8'h0;
        end else if (wr) begin
            cfg_r   <= (paddr == 32'h2C) ? (pwdata & 32'h3F) : cfg_r;
            fHold_r <= (paddr == 32'h30) ? pwdata : fHold_r;
            pHold_r <= (paddr == 32'h34) ? pwdata[7:0] : pHold_r;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence fStb_s;
        wr && paddr == 32'h38;
    endsequence
    sequence pStb_s;
        wr && paddr == 32'h3C;
    endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    bad_addr_a: assert property (psel && penable && paddr == 32'h40 |-> pslverr)
        else $error("no slave error");
    freq_strobe_a: assert property (fStb_s |=> activeFreq == $past(fHold_r))
        else $error("frequency strobe lost");
    phase_strobe_a: assert property (pStb_s |=> activePhase == $past(pHold_r))
        else $error("phase strobe lost");
    sync_load_a: assert property (syncOn |=> activeFreq == $past(fHold_r)
        && activePhase == $past(pHold_r)) else $error("sync load lost");
    freq_hold_a: assert property ($changed(activeFreq) |->
        $past(wr && paddr == 32'h38) || $past(syncOn)) else $error("frequency moved");
    phase_hold_a: assert property ($changed(activePhase) |->
        $past(wr && paddr == 32'h3C) || $past(syncOn)) else $error("phase moved");
    clear_acc_a: assert property (cfg_r[1] && $past(cfg_r[1]) && !$past(resampleTick)
        |-> phaseAccum == 32'h0) else $error("accumulator not cleared");
    load_zero_a: assert property (syncOn && cfg_r[0] && !resampleTick
        |=> phaseAccum == 32'h0) else $error("load kept feedback");
    acc_step_a: assert property (resampleTick && cfg_r[2:0] == 3'h0
        && $stable(cfg_r) |=> phaseAccum == $past(phaseAccum) + $past(activeFreq))
        else $error("bad step");
endmodule
bind timing_nco_control timing_nco_control_chk chk (.clock, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .external_sync_in, .resampleTick, .activeFreq,
    .activePhase, .phaseAccum);

// ### bench/sync_source.sv
// partner: resampler tick and external sync source
`timescale 1ns/1ps
module sync_source (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // requests
    input  wire logic [3:0] gap,
    input  wire logic       syncReq,
    // pulses
    output logic            tick,
    output logic            sync
);
    logic [3:0] cnt_r;
    // one tick every gap+1 cycles, none while gap is zero
    always_ff @(posedge clock) begin
        if (!rstn || gap == 4'h0) begin
            cnt_r <= 4'h0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == gap) ? 4'h0 : cnt_r + 4'h1;
            tick  <= cnt_r == gap;
        end
        sync <= rstn && syncReq;
    end
endmodule

// ### bench/timing_nco_control_test.sv
// testbench: timing oscillator control against a behavioural model
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch %0t %h %h", $time, a, e); end end
module timing_nco_control_test;
    logic        clock, rstn, psel, penable, pwrite, syncReq, pready, pslverr, tick, sync;
    logic [31:0] paddr, pwdata, prdata, activeFreq, phaseAccum, ncoPhase;
    logic [7:0]  activePhase;
    logic [3:0]  gap;
    int          n_fail = 0, checked = 0, seed = 32'h3B0BFDAB;
    bit   [31:0] cfg, fHold, pHold, ofs, aFreq, aPhase, acc, nco;
    timing_nco_control dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .external_sync_in(sync), .resampleTick(tick), .activeFreq,
        .activePhase, .ncoPhase, .phaseAccum);
    sync_source src (.clock, .rstn, .gap, .syncReq, .tick, .sync);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        bit          w, ld, zero;
        bit   [31:0] ofsE;
        w  = psel && penable && pwrite;
        ld = sync && cfg[5];
        if (!rstn) begin
            {cfg, fHold, pHold, ofs, aFreq, aPhase, acc, nco} = '0;
        end else begin
            zero = cfg[1] || cfg[0] && (ld || w && paddr == 32'h38);
            ofsE = cfg[2] ? ofs & (32'hFFFFFFFF >> 8 * (3 - cfg[4:3])) : 0;
            acc  = (zero ? 0 : acc) + (tick ? aFreq + ofsE : 0);
            // phase output uses the active offset from before this edge
            nco  = acc + (aPhase << 24);
            if (ld || w && paddr == 32'h38) aFreq = fHold;
            if (ld || w && paddr == 32'h3C) aPhase = pHold;
            if (w && paddr == 32'h2C) cfg = pwdata & 32'h3F;
            if (w && paddr == 32'h30) fHold = pwdata;
            if (w && paddr == 32'h34) pHold = pwdata & 32'hFF;
            if (w && paddr == 32'h80) ofs = pwdata;
        end
    end
    always @(negedge clock) begin
        if (rstn) begin
            `CHK(activeFreq, aFreq)
            `CHK(activePhase, aPhase[7:0])
            `CHK(phaseAccum, acc)
            `CHK(ncoPhase, nco)
        end
    end
    function automatic bit [31:0] expRead(input bit [31:0] a);
        case (a)
            32'h2C:  expRead = cfg;
            32'h30:  expRead = fHold;
            32'h34:  expRead = pHold;
            32'h80:  expRead = ofs;
            32'h84:  expRead = aFreq;
            32'h88:  expRead = aPhase;
            32'h8C:  expRead = acc;
            default: expRead = 0;
        endcase
    endfunction
    task automatic apb(input bit w, input bit [31:0] a, input bit [31:0] d);
        bit bad;
        bad = !(a inside {32'h2C, 32'h30, 32'h34, 32'h38, 32'h3C, 32'h80, 32'h84, 32'h88,
            32'h8C});
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        `CHK(pslverr, bad)
        if (!w) `CHK(prdata, expRead(a))
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse();
        @(posedge clock);
        syncReq <= 1'b1;
        @(posedge clock);
        syncReq <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, syncReq, paddr, pwdata, gap, rstn} = '0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 25; i++) apb(1'b0, 32'h2C + 4 * i, 0);
        apb(1'b1, 32'h30, $random(seed));
        apb(1'b0, 32'h31, 0);
        apb(1'b1, 32'h34, $random(seed));
        apb(1'b1, 32'h40, $random(seed));
        apb(1'b1, 32'h38, $random(seed));
        apb(1'b1, 32'h3C, 0);
        apb(1'b1, 32'h30, $random(seed));
        pulse();
        apb(1'b1, 32'h2C, 32'h20);
        pulse();
        apb(1'b1, 32'h80, $random(seed));
        gap <= 4'h2;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 32'h2C, 32'(i) << 2);
            repeat (10) @(posedge clock);
        end
        apb(1'b1, 32'h2C, 32'h2);
        repeat (8) @(posedge clock);
        apb(1'b1, 32'h2C, 32'h21);
        gap <= 4'hF;
        apb(1'b1, 32'h38, 0);
        pulse();
        // read back the loaded values while they are non-zero
        for (int i = 0; i < 3; i++) apb(1'b0, 32'h2C + 4 * i, 0);
        for (int i = 0; i < 3; i++) apb(1'b0, 32'h80 + 4 * i, 0);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, 32'h2C, 0);
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        give_verdict();
    end
endmodule
